// *** hw/vdss_pkg.sv ***
package vdss_pkg;
	// fixed slave address on the two-wire bus (1001111)
	localparam logic [6:0] DEV_ADDR = 7'h4f;
	// non-volatile byte as shipped; the code is its upper seven bits
	localparam logic [7:0] NV_FACTORY = 8'h80;
	localparam logic [6:0] NV_FACTORY_CODE = NV_FACTORY[7:1];
	// rw bit values in the address byte
	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	// target selector in a written data byte (lsb)
	localparam logic SEL_VOLATILE = 1'b1;
	// timing, at a 25 ns clock
	localparam int unsigned CLK_NS = 25;
	localparam int unsigned T_W_MS = 100;
	// longest programming time rounds down to whole cycles
	localparam int unsigned T_PROG_CYC = (T_W_MS * 1000000) / CLK_NS;
	localparam int unsigned T_QTR_NS = 625;
	// least quarter of a 400 kHz bus clock rounds up
	localparam int unsigned T_QTR_CYC = (T_QTR_NS + CLK_NS - 1) / CLK_NS;
	// bit count of one byte, and host frame layout
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [4:0] FR_ADDR_ACK = 5'h08;
	localparam logic [4:0] FR_LAST = 5'h11;
	// host register byte addresses and fields
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int unsigned CTRL_GO_BIT = 0;
	localparam int unsigned CTRL_RD_BIT = 1;
	localparam int unsigned CTRL_DATA_LSB = 8;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_NACK_BIT = 1;
	localparam int unsigned STAT_DATA_LSB = 8;
endpackage : vdss_pkg

// *** hw/vdss_if.sv ***
`timescale 1ns/1ps
// two-wire bus; each party pulls a line low while its enable is high
interface vdss_if;
	logic m_scl_o; // host clock line level when driving
	logic m_scl_oe; // host pulls the clock line
	logic m_sda_o; // host data level when driving
	logic m_sda_oe; // host pulls the data line
	logic s_sda_o; // device data level when driving
	logic s_sda_oe; // device pulls the data line
	logic scl; // resolved clock line, pulled up
	logic sda; // resolved data line, pulled up

	// wired-and with pull-ups
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

	modport master (
		output m_scl_o,
		output m_scl_oe,
		output m_sda_o,
		output m_sda_oe,
		input scl,
		input sda
	);
	modport slave (
		output s_sda_o,
		output s_sda_oe,
		input scl,
		input sda
	);
endinterface : vdss_if

// *** hw/vdss_dev.sv ***
`timescale 1ns/1ps
module vdss_dev #(
	parameter int unsigned PROG_CYCLES = vdss_pkg::T_PROG_CYC // programming time
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wp_n_i, // high allows writes
	vdss_if.slave bus,
	output logic [6:0] code_o, // code for the current sink
	output logic prog_busy_o // non-volatile programming in progress
);
	import vdss_pkg::*;
	localparam int unsigned PW = $clog2(PROG_CYCLES + 1);
	localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYCLES - 1);
	// one-hot protocol states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01, // bus free or after stop
		ST_ADDR = 8'h02, // shifting in the address byte
		ST_AACK = 8'h04, // acknowledging the address
		ST_WDAT = 8'h08, // shifting in a data byte
		ST_WACK = 8'h10, // acknowledging a data byte
		ST_RDAT = 8'h20, // shifting out the code byte
		ST_RACK = 8'h40, // master's acknowledge slot
		ST_SKIP = 8'h80 // not for us; wait for next start
	} vdss_state_e;
	vdss_state_e state_q, state_d;
	logic scl_q, scl_d; // previous clock line sample
	logic sda_q, sda_d; // previous data line sample
	logic [3:0] cnt_q, cnt_d; // bit counter inside a byte
	logic [7:0] sh_q, sh_d; // shift register
	logic rw_q, rw_d; // direction of the current transfer
	logic oe_q, oe_d; // we pull the data line low
	logic [6:0] code_q, code_d; // volatile code register
	logic [6:0] nv_q = NV_FACTORY_CODE, nv_d; // store; kept out of reset for the recall
	logic load_q, load_d; // power-up recall still pending
	logic busy_q, busy_d; // programming in progress
	logic [PW-1:0] pcnt_q, pcnt_d; // programming time counter
	logic rise, fall, start_c, stop_c;
	// line events; the pins are taken as synchronous to clk_i
	always_comb
	begin
		rise = bus.scl && !scl_q;
		fall = !bus.scl && scl_q;
		// only a data change with the clock high both samples is a condition
		start_c = bus.scl && scl_q && sda_q && !bus.sda;
		stop_c = bus.scl && scl_q && !sda_q && bus.sda;
	end
	// next-state logic for the whole block
	always_comb
	begin
		state_d = state_q;
		scl_d = bus.scl;
		sda_d = bus.sda;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rw_d = rw_q;
		oe_d = oe_q;
		code_d = code_q;
		nv_d = nv_q;
		load_d = 1'b0;
		busy_d = busy_q;
		pcnt_d = pcnt_q;
		// recall the stored code once after reset release
		if (load_q)
			code_d = nv_q;
		// programming timer; the store itself was taken at the ack
		if (busy_q)
		begin
			if (pcnt_q == PROG_LAST)
			begin
				busy_d = 1'b0;
				pcnt_d = '0;
			end
			else
				pcnt_d = pcnt_q + 1'b1;
		end
		if (start_c)
		begin
			// a start anywhere, repeated or not, restarts the address phase
			state_d = ST_ADDR;
			cnt_d = '0;
			oe_d = 1'b0;
		end
		else if (stop_c)
		begin
			state_d = ST_IDLE;
			oe_d = 1'b0;
		end
		else
		begin
			case (state_q)
				ST_ADDR:
				begin
					// sample on rising clock, msb arrives first
					if (rise)
					begin
						sh_d = {sh_q[6:0], bus.sda};
						cnt_d = cnt_q + 1'b1;
					end
					// after the eighth bit, decide at the falling clock
					if (fall && cnt_q == BYTE_BITS)
					begin
						if (sh_q[7:1] == DEV_ADDR && !(sh_q[0] == RW_WRITE && busy_q))
						begin
							oe_d = 1'b1;
							rw_d = sh_q[0];
							state_d = ST_AACK;
						end
						else
							state_d = ST_SKIP;
					end
				end
				ST_AACK:
				begin
					// ack held across the whole high phase; on the fall a write drops it, a read drives the first code bit
					if (fall)
					begin
						cnt_d = '0;
						if (rw_q == RW_READ)
						begin
							// lsb of the read byte carries no meaning; send zero
							sh_d = {code_q, 1'b0};
							oe_d = !code_q[6];
							state_d = ST_RDAT;
						end
						else
						begin
							oe_d = 1'b0;
							state_d = ST_WDAT;
						end
					end
				end
				ST_WDAT:
				begin
					if (rise)
					begin
						sh_d = {sh_q[6:0], bus.sda};
						cnt_d = cnt_q + 1'b1;
					end
					if (fall && cnt_q == BYTE_BITS)
					begin
						// busy shows as a missing acknowledge
						if (busy_q)
							state_d = ST_SKIP;
						else
						begin
							oe_d = 1'b1;
							state_d = ST_WACK;
							// protect low drops the byte but it is still acknowledged
							if (wp_n_i && sh_q[0] == SEL_VOLATILE)
								code_d = sh_q[7:1];
							else if (wp_n_i)
							begin
								nv_d = sh_q[7:1];
								busy_d = 1'b1;
								pcnt_d = '0;
							end
						end
					end
				end
				ST_WACK:
				begin
					// further bytes are accepted the same way
					if (fall)
					begin
						oe_d = 1'b0;
						cnt_d = '0;
						state_d = ST_WDAT;
					end
				end
				ST_RDAT:
				begin
					// change data only just after the falling clock
					if (fall)
					begin
						cnt_d = cnt_q + 1'b1;
						if (cnt_q == BYTE_BITS - 4'h1)
						begin
							oe_d = 1'b0;
							state_d = ST_RACK;
						end
						else
						begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = !sh_q[6];
						end
					end
				end
				ST_RACK:
				begin
					// high in the slot means the master is done reading
					if (rise && bus.sda)
						state_d = ST_SKIP;
					else if (fall)
					begin
						cnt_d = '0;
						sh_d = {code_q, 1'b0};
						oe_d = !code_q[6];
						state_d = ST_RDAT;
					end
				end
				// idle and skip keep the line released
				default: oe_d = 1'b0;
			endcase
		end
	end
	// registers; the store is kept apart so that reset leaves it alone
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= ST_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
			code_q <= NV_FACTORY_CODE;
			load_q <= 1'b1;
			busy_q <= 1'b0;
			pcnt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
			code_q <= code_d;
			load_q <= load_d;
			busy_q <= busy_d;
			pcnt_q <= pcnt_d;
		end
	end
	// store register without reset: a power-up must find the last stored code
	always_ff @(posedge clk_i)
		nv_q <= nv_d;
	// open drain: only ever pulls low
	assign bus.s_sda_o = 1'b0;
	assign bus.s_sda_oe = oe_q;
	// plain binary code, so a larger value sinks more current
	assign code_o = code_q;
	assign prog_busy_o = busy_q;
endmodule : vdss_dev

// *** hw/vdss_host.sv ***
`timescale 1ns/1ps
// bus master: one write or one read transfer per command
module vdss_host #(
	parameter int unsigned QTR_CYCLES = vdss_pkg::T_QTR_CYC // quarter bit time
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i, // byte address
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	vdss_if.master bus
);
	import vdss_pkg::*;

	localparam int unsigned QW = $clog2(QTR_CYCLES + 1);
	localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYCLES - 1);

	typedef enum logic [3:0] {
		H_IDLE = 4'h1, // waiting for a command
		H_START = 4'h2, // data low with clock high
		H_BIT = 4'h4, // eighteen clocked bits
		H_STOP = 4'h8 // data rises with clock high
	} vdss_hstate_e;

	vdss_hstate_e state_q, state_d;
	logic [QW-1:0] qcnt_q, qcnt_d; // quarter bit timer
	logic [1:0] ph_q, ph_d; // quarter within a bit
	logic [4:0] idx_q, idx_d; // bit index in the frame
	logic [17:0] fr_q, fr_d; // bits to send, one means released
	logic rw_q, rw_d; // current transfer reads
	logic nack_q, nack_d; // a device acknowledge was missing
	logic [7:0] rbyte_q, rbyte_d; // byte read back
	logic scl_oe_q, scl_oe_d; // clock line pulled low
	logic sda_oe_q, sda_oe_d; // data line pulled low
	logic wait_q, wait_d; // avalon waitrequest
	logic [31:0] rdata_q, rdata_d; // avalon read data
	logic tick, acc, go;

	// avalon slave: every access answers one cycle after it is seen
	always_comb
	begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		acc = (avs_read_i || avs_write_i) && wait_q;
		// commands to a busy master are dropped rather than queued
		go = avs_write_i && !wait_q && avs_address_i == REG_CTRL
			&& avs_byteenable_i[0] && avs_writedata_i[CTRL_GO_BIT] && state_q == H_IDLE;
		if (acc)
		begin
			wait_d = 1'b0;
			rdata_d = 32'h0000_0000;
			if (avs_address_i == REG_STAT)
			begin
				rdata_d[STAT_BUSY_BIT] = state_q != H_IDLE;
				rdata_d[STAT_NACK_BIT] = nack_q;
				rdata_d[STAT_DATA_LSB +: 8] = rbyte_q;
			end
			else if (avs_address_i == REG_CTRL)
			begin
				rdata_d[CTRL_RD_BIT] = rw_q;
			end
		end
	end

	// bus sequencer, one step per quarter bit
	always_comb
	begin
		state_d = state_q;
		qcnt_d = qcnt_q;
		ph_d = ph_q;
		idx_d = idx_q;
		fr_d = fr_q;
		rw_d = rw_q;
		nack_d = nack_q;
		rbyte_d = rbyte_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		tick = qcnt_q == QTR_LAST;
		if (state_q != H_IDLE)
		begin
			qcnt_d = tick ? '0 : qcnt_q + 1'b1;
		end
		case (state_q)
			H_IDLE:
			begin
				// bus is idle with both lines released here
				if (go)
				begin
					rw_d = avs_writedata_i[CTRL_RD_BIT];
					// address, rw, ack slot, data or released, last ack slot
					fr_d = {DEV_ADDR, avs_writedata_i[CTRL_RD_BIT], 1'b1,
						avs_writedata_i[CTRL_RD_BIT] ? 8'hff
						: avs_writedata_i[CTRL_DATA_LSB +: 8], 1'b1};
					nack_d = 1'b0;
					qcnt_d = '0;
					sda_oe_d = 1'b1;
					state_d = H_START;
				end
			end
			H_START:
			begin
				if (tick)
				begin
					scl_oe_d = 1'b1;
					ph_d = 2'h0;
					idx_d = '0;
					state_d = H_BIT;
				end
			end
			H_BIT:
			begin
				if (tick)
				begin
					ph_d = ph_q + 2'h1;
					case (ph_q)
						2'h0: sda_oe_d = !fr_q[17];
						2'h1: scl_oe_d = 1'b0;
						2'h2:
						begin
							// sample in the middle of the high phase
							if ((idx_q == FR_ADDR_ACK || (idx_q == FR_LAST && !rw_q)) && bus.sda)
							begin
								nack_d = 1'b1;
							end
							if (idx_q > FR_ADDR_ACK && idx_q < FR_LAST)
							begin
								rbyte_d = {rbyte_q[6:0], bus.sda};
							end
						end
						default:
						begin
							scl_oe_d = 1'b1;
							fr_d = {fr_q[16:0], 1'b1};
							idx_d = idx_q + 5'h01;
							// an unanswered address ends the transfer early
							if (idx_q == FR_LAST || (idx_q == FR_ADDR_ACK && nack_q))
							begin
								state_d = H_STOP;
							end
						end
					endcase
				end
			end
			default:
			begin
				if (tick)
				begin
					ph_d = ph_q + 2'h1;
					case (ph_q)
						2'h0: sda_oe_d = 1'b1;
						2'h1: scl_oe_d = 1'b0;
						2'h2: sda_oe_d = 1'b0;
						default: state_d = H_IDLE;
					endcase
				end
			end
		endcase
	end

	// registers
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= H_IDLE;
			qcnt_q <= '0;
			ph_q <= 2'h0;
			idx_q <= 5'h00;
			fr_q <= 18'h3ffff;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			rbyte_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			state_q <= state_d;
			qcnt_q <= qcnt_d;
			ph_q <= ph_d;
			idx_q <= idx_d;
			fr_q <= fr_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			rbyte_q <= rbyte_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	assign bus.m_scl_o = 1'b0;
	assign bus.m_scl_oe = scl_oe_q;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe = sda_oe_q;
	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
endmodule : vdss_host

// *** test/vdss_assertions.sv ***
`timescale 1ns/1ps
// watches the joined link and the device outputs; one clock domain
module vdss_assertions #(
	parameter int unsigned PROG_CYCLES = vdss_pkg::T_PROG_CYC // programming time in clocks
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wp_n_i, // device write protect
	input wire logic [6:0] code_i, // device code output
	input wire logic prog_busy_i, // device programming flag
	input wire logic m_sda_oe_i, // host pulls the data line
	input wire logic s_sda_oe_i, // device pulls the data line
	input wire logic scl_i, // resolved clock line
	input wire logic sda_i // resolved data line
);
	logic [31:0] busy_cnt_q; // clocks of the current busy period
	logic [31:0] busy_cnt_d;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// next count: cleared while idle so each period starts from zero
	always_comb
	begin
		busy_cnt_d = prog_busy_i ? busy_cnt_q + 32'h1 : 32'h0;
	end
	// count register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			busy_cnt_q <= 32'h0;
		else
			busy_cnt_q <= busy_cnt_d;
	end
	// under a high clock only the master may move data (start or stop)
	chk_sda_high_stable: assert property (
		scl_i && $past(scl_i) && $changed(sda_i) |-> $changed(m_sda_oe_i))
		else $error("data line moved under high clock");
	chk_dev_change_low: assert property (
		$changed(s_sda_oe_i) |-> !scl_i)
		else $error("device changed data while clock high");
	chk_ack_held_high: assert property (
		s_sda_oe_i && scl_i |=> s_sda_oe_i)
		else $error("device let go during clock high");
	chk_stop_released: assert property (
		$rose(sda_i) && $past(scl_i) && scl_i |=> !s_sda_oe_i [*4])
		else $error("device drives after stop");
	chk_start_idle: assert property (
		$rose(m_sda_oe_i) && scl_i |-> $past(sda_i) && $past(scl_i))
		else $error("start on busy bus");
	chk_wp_code_hold: assert property (
		!wp_n_i && $past(rst_n_i, 2) |=> $stable(code_i))
		else $error("code changed while protected");
	chk_wp_no_prog: assert property (
		$rose(prog_busy_i) |-> $past(wp_n_i))
		else $error("programming while protected");
	chk_busy_length: assert property (
		$fell(prog_busy_i) |-> busy_cnt_q == PROG_CYCLES)
		else $error("programming period wrong length");
	chk_store_keeps: assert property (
		$rose(prog_busy_i) |-> $stable(code_i))
		else $error("store changed live code");
endmodule : vdss_assertions

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import vdss_pkg::*;
	localparam int unsigned PROG = 600; // long enough to overlap the next address
	logic clk_i = 1'b0; // 40 MHz
	logic rst_n_i = 1'b0;
	logic wp_n_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wait_o;
	logic [6:0] code_o;
	logic busy_o;
	int errors = 0;
	int cmp_count = 0;
	vdss_if u_vdss_if ();
	vdss_dev #(.PROG_CYCLES(PROG)) u_vdss_dev (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.wp_n_i(wp_n_i), .bus(u_vdss_if.slave), .code_o(code_o), .prog_busy_o(busy_o));
	// short quarter bit keeps each transfer near 300 clocks
	vdss_host #(.QTR_CYCLES(4)) u_vdss_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
		.bus(u_vdss_if.master));
	vdss_assertions #(.PROG_CYCLES(PROG)) u_vdss_assertions (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .wp_n_i(wp_n_i), .code_i(code_o), .prog_busy_i(busy_o),
		.m_sda_oe_i(u_vdss_if.m_sda_oe), .s_sda_oe_i(u_vdss_if.s_sda_oe),
		.scl_i(u_vdss_if.scl), .sda_i(u_vdss_if.sda));
	always #12.5 clk_i = ~clk_i;
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	// a used-up wait ends the run at once
	task automatic tmo(input int n, input int lim);
		if (n >= lim)
		begin
			$display("MISMATCH wait expected done seen timeout");
			errors++;
			test_done();
		end
	endtask : tmo
	// one avalon access, held until waitrequest is sampled low
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		@(posedge clk_i);
		while (wait_o !== 1'b0 && n < 100)
		begin
			@(posedge clk_i);
			n++;
		end
		tmo(n, 100);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_i);
	endtask : av
	// one link transfer, then status once the host is idle
	task automatic xfer(input logic r, input logic [7:0] b, output logic [31:0] st);
		int n;
		n = 0;
		av(1'b1, REG_CTRL, {16'h0, b, 6'h0, r, 1'b1}, st);
		av(1'b0, REG_STAT, 32'h0, st);
		while (st[STAT_BUSY_BIT] !== 1'b0 && n < 400)
		begin
			av(1'b0, REG_STAT, 32'h0, st);
			n++;
		end
		tmo(n, 400);
	endtask : xfer
	task automatic do_reset;
		rst_n_i <= 1'b0;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// the recall lands on the first edge after release; look after the second
		repeat (2) @(posedge clk_i);
	endtask : do_reset
	task automatic t_reset;
		logic [31:0] st;
		chk("code", 32'(NV_FACTORY_CODE), 32'(code_o));
		chk("busy", 32'h0, 32'(busy_o));
		xfer(1'b1, 8'h00, st);
		chk("nack", 32'h0, 32'(st[STAT_NACK_BIT]));
		chk("rd byte", 32'(NV_FACTORY_CODE), 32'(st[STAT_DATA_LSB+1 +: 7]));
		av(1'b0, REG_CTRL, 32'h0, st);
		chk("ctrl dir", 32'h0000_0002, st);
		$display("test reset done");
	endtask : t_reset
	// both end codes and 7'h2a written then read back
	task automatic t_vol;
		logic [31:0] st;
		logic [6:0] c [3] = '{7'h00, 7'h7f, 7'h2a};
		foreach (c[i])
		begin
			xfer(1'b0, {c[i], SEL_VOLATILE}, st);
			chk("wr nack", 32'h0, 32'(st[STAT_NACK_BIT]));
			chk("code", 32'(c[i]), 32'(code_o));
			xfer(1'b1, 8'h00, st);
			chk("rd byte", 32'(c[i]), 32'(st[STAT_DATA_LSB+1 +: 7]));
		end
		$display("test volatile done");
	endtask : t_vol
	task automatic t_wp;
		logic [31:0] st;
		wp_n_i <= 1'b0;
		@(posedge clk_i);
		xfer(1'b0, {7'h11, SEL_VOLATILE}, st);
		chk("wp code", 32'h2a, 32'(code_o));
		xfer(1'b0, {7'h22, 1'b0}, st);
		chk("wp busy", 32'h0, 32'(busy_o));
		wp_n_i <= 1'b1;
		@(posedge clk_i);
		$display("test protect done");
	endtask : t_wp
	// store, refused write while busy, then recall at reset
	task automatic t_nv;
		logic [31:0] st;
		int n;
		n = 0;
		xfer(1'b0, {7'h33, 1'b0}, st);
		chk("nv busy", 32'h1, 32'(busy_o));
		chk("nv code", 32'h2a, 32'(code_o));
		xfer(1'b0, {7'h55, SEL_VOLATILE}, st);
		chk("busy nack", 32'h1, 32'(st[STAT_NACK_BIT]));
		chk("busy code", 32'h2a, 32'(code_o));
		while (busy_o !== 1'b0 && n < 2000)
		begin
			@(posedge clk_i);
			n++;
		end
		tmo(n, 2000);
		do_reset();
		chk("recall", 32'h33, 32'(code_o));
		$display("test store done");
	endtask : t_nv
	initial
	begin
		do_reset();
		t_reset();
		t_vol();
		t_wp();
		t_nv();
		test_done();
	end
endmodule : tb_top
